// [hdl/uec_defines.vh]
`ifndef UEC_DEFINES_VH
`define UEC_DEFINES_VH

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define UEC_CSR_ADDR 32'hF00E0020
`define UEC_CSR_RESET 32'h00000401

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define UEC_MAX_PACKET_SIZE_CODE_LSB 0
`define UEC_MAX_PACKET_SIZE_CODE_MSB 2
`define UEC_SIZE_WE_BIT 7
`define UEC_OUT_ISO_BIT 8
`define UEC_OUT_ACLR_BIT 9
`define UEC_DIR_BIT 10
`define UEC_IN_ISO_BIT 11
`define UEC_IN_ASET_BIT 12
`define UEC_MODE_WE_BIT 15
`define UEC_ORDY_BIT 16
`define UEC_FILL_BIT 17
`define UEC_OVER_BIT 18
`define UEC_DERR_BIT 19
`define UEC_IRDY_BIT 24

// ----------------------------------------------------------------------
// reset values of fields
// ----------------------------------------------------------------------
`define UEC_MAX_PACKET_SIZE_CODE_RST 3'h1
`define UEC_DIR_RST 1'b1
`define UEC_OUT_ISO_RST 1'b0
`define UEC_IN_ISO_RST 1'b0

// ----------------------------------------------------------------------
// size code to byte count
// ----------------------------------------------------------------------
`define UEC_BYTES_PER_CODE 6'h08

`endif

// [hdl/uec_ep2_csr.v]
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`include "uec_defines.vh"

// What this block does
// - size code maps to eight-byte steps
// - size field written only with size enable
// - bits 12:8 written only with mode enable
// - direction bit, one is IN, resets IN
// - mode bits act only in their direction
// - OUT iso select, bulk at zero
// - IN iso select, bulk at zero
// - auto set IN ready on full packet
// - core sets OUT ready on packet load
// - fill state reports packets in FIFO
// - OUT iso overrun on failed load
// - OUT iso data error flagged
// - data error clears with OUT ready
// - register address and reset value
// - IN ready blocks FIFO writes while set
module uec_ep2_csr #(
  parameter FIFO_BYTES = 32
) (
  // clock and reset
  input wire core_clk_i,
  input wire arst_n_i,
  // apb slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [31:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  // usb core, OUT side
  input wire out_pkt_loaded_i,
  input wire out_pkt_error_i,
  input wire out_load_fail_i,
  // mcu fifo access
  input wire fifo_read_i,
  input wire fifo_write_i,
  // usb core, IN side
  input wire in_pkt_sent_i,
  // control to the endpoint logic
  output wire [5:0] max_packet_bytes_o,
  output wire dir_in_o,
  output wire out_iso_o,
  output wire in_iso_o,
  output wire fifo_write_ok_o,
  output wire out_packet_ready_o,
  output wire in_packet_ready_o
);

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  reg [2:0] max_packet_size_code_q;
  reg dir_q;
  reg out_isochronous_select_q;
  reg oaclr_q;
  reg in_isochronous_select_q;
  reg iaset_q;
  reg [1:0] npkt_q; // packets held in OUT fifo
  reg err0_q; // error tag of packet at head
  reg err1_q; // error tag of second packet
  reg over_q;
  reg [5:0] ocnt_q; // bytes left in head OUT packet
  reg [5:0] olen1_q; // size of second queued packet
  reg [5:0] icnt_q; // bytes written to IN fifo
  reg irdy_q;
  wire [5:0] mp_bytes;
  wire wr_en;
  wire rd_en;
  wire hit;
  wire is_out;
  wire is_in;
  wire big_pkt;
  wire unload_done;
  wire mcu_clr_ordy;
  wire mcu_set_irdy;
  wire pop;
  wire push;
  wire fifo_full;
  wire [1:0] fill;
  wire [31:0] rd_word;

  // --------------------------------------------------------------------
  // size decode
  // --------------------------------------------------------------------
  uec_size_decode u_dec (
    .code_i(max_packet_size_code_q),
    .bytes_o(mp_bytes)
  );

  // --------------------------------------------------------------------
  // apb decode, zero wait states
  // --------------------------------------------------------------------
  assign hit = (paddr_i == `UEC_CSR_ADDR);
  assign wr_en = psel_i & penable_i & pwrite_i & hit;
  assign rd_en = psel_i & penable_i & ~pwrite_i & hit;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~hit; // unmapped address

  // direction gating
  assign is_out = ~dir_q;
  assign is_in = dir_q;
  assign big_pkt = (mp_bytes > FIFO_BYTES[5:0]);

  // --------------------------------------------------------------------
  // configuration fields
  // --------------------------------------------------------------------
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      max_packet_size_code_q <= `UEC_MAX_PACKET_SIZE_CODE_RST;
      dir_q <= `UEC_DIR_RST;
      out_isochronous_select_q <= `UEC_OUT_ISO_RST;
      oaclr_q <= 1'b0;
      in_isochronous_select_q <= `UEC_IN_ISO_RST;
      iaset_q <= 1'b0;
    end else if (wr_en) begin
      if (pwdata_i[`UEC_SIZE_WE_BIT]) begin
        max_packet_size_code_q <= pwdata_i[`UEC_MAX_PACKET_SIZE_CODE_MSB:`UEC_MAX_PACKET_SIZE_CODE_LSB];
      end
      if (pwdata_i[`UEC_MODE_WE_BIT]) begin
        out_isochronous_select_q <= pwdata_i[`UEC_OUT_ISO_BIT];
        oaclr_q <= pwdata_i[`UEC_OUT_ACLR_BIT];
        dir_q <= pwdata_i[`UEC_DIR_BIT];
        in_isochronous_select_q <= pwdata_i[`UEC_IN_ISO_BIT];
        iaset_q <= pwdata_i[`UEC_IN_ASET_BIT];
      end
    end
  end

  // --------------------------------------------------------------------
  // OUT packet queue
  // --------------------------------------------------------------------
  // head unload finishes on the read that takes the last byte
  assign unload_done = is_out & fifo_read_i & (npkt_q != 2'h0) &
                       (ocnt_q <= 6'h01);
  // software clears ready by writing one to bit 16
  assign mcu_clr_ordy = wr_en & is_out & pwdata_i[`UEC_ORDY_BIT];
  assign pop = (npkt_q != 2'h0) &
               (mcu_clr_ordy | (oaclr_q & unload_done));
  assign fifo_full = big_pkt ? (npkt_q != 2'h0) : (npkt_q == 2'h2);
  assign push = is_out & out_pkt_loaded_i & ~fifo_full;

  // queue depth, error tags and byte counts
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      npkt_q <= 2'h0;
      err0_q <= 1'b0;
      err1_q <= 1'b0;
      ocnt_q <= 6'h00;
      olen1_q <= 6'h00;
    end else begin
      if (push & ~pop) begin
        npkt_q <= npkt_q + 2'h1;
      end else if (pop & ~push) begin
        npkt_q <= npkt_q - 2'h1;
      end
      // the second packet's error moves to the head only after the pop
      if (pop) begin
        err0_q <= (npkt_q == 2'h2) ? err1_q : (push & out_pkt_error_i);
        ocnt_q <= (npkt_q == 2'h2) ? olen1_q : mp_bytes;
        err1_q <= push & (npkt_q == 2'h2) & out_pkt_error_i;
        olen1_q <= mp_bytes;
      end else if (push & (npkt_q == 2'h0)) begin
        err0_q <= out_pkt_error_i;
        ocnt_q <= mp_bytes;
      end else if (push) begin
        err1_q <= out_pkt_error_i;
        olen1_q <= mp_bytes;
      end else if (is_out & fifo_read_i & (ocnt_q != 6'h00)) begin
        ocnt_q <= ocnt_q - 6'h01;
      end
    end
  end

  // overrun: iso packet arrives with no room; set wins over clear
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      over_q <= 1'b0;
    end else if (is_out & out_isochronous_select_q & (out_load_fail_i |
                 (out_pkt_loaded_i & fifo_full))) begin
      over_q <= 1'b1;
    end else if (wr_en & pwdata_i[`UEC_OVER_BIT]) begin
      over_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // IN packet ready
  // --------------------------------------------------------------------
  assign fifo_write_ok_o = is_in & ~irdy_q;
  assign mcu_set_irdy = wr_en & is_in & pwdata_i[`UEC_IRDY_BIT];

  // counts bytes loaded; auto set on a full packet
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      icnt_q <= 6'h00;
      irdy_q <= 1'b0;
    end else begin
      if (mcu_set_irdy) begin
        irdy_q <= 1'b1;
        icnt_q <= 6'h00;
      end else if (fifo_write_i & fifo_write_ok_o) begin
        if (iaset_q & (icnt_q + 6'h01 >= mp_bytes)) begin
          irdy_q <= 1'b1;
          icnt_q <= 6'h00;
        end else begin
          icnt_q <= icnt_q + 6'h01;
        end
      end else if (in_pkt_sent_i & irdy_q) begin
        irdy_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // read data and status outputs
  // --------------------------------------------------------------------
  assign fill = (npkt_q == 2'h0) ? 2'b00 :
                (fifo_full ? 2'b11 : 2'b01);
  assign out_packet_ready_o = is_out & (npkt_q != 2'h0);
  assign in_packet_ready_o = irdy_q;
  // reserved bits, enables and the unused upper bits read zero
  assign rd_word = {7'h00, irdy_q, 4'h0,
                    is_out & out_isochronous_select_q & err0_q & (npkt_q != 2'h0),
                    over_q, fill, 3'h0, iaset_q, in_isochronous_select_q, dir_q, oaclr_q,
                    out_isochronous_select_q, 1'b0, 4'h0, max_packet_size_code_q};
  assign prdata_o = rd_en ? rd_word : 32'h00000000;
  // data error follows OUT ready, so it drops with it

  // control outputs, each mode bit gated by direction
  assign max_packet_bytes_o = mp_bytes;
  assign dir_in_o = dir_q;
  assign out_iso_o = is_out & out_isochronous_select_q;
  assign in_iso_o = is_in & in_isochronous_select_q;

endmodule // uec_ep2_csr

// [hdl/uec_size_decode.v]
`timescale 1ns/1ps
`include "uec_defines.vh"

// code 000..100 maps to 0..32 bytes; codes above 100 clamp to 32
module uec_size_decode (
  // size code
  input wire [2:0] code_i,
  // size in bytes
  output reg [5:0] bytes_o
);

  // multiply the code by eight, clamped at the largest legal code
  always @* begin
    if (code_i > 3'h4) begin
      bytes_o = 6'h20;
    end else begin
      bytes_o = {code_i, 3'h0};
    end
  end

endmodule // uec_size_decode

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
  localparam logic [31:0] CSR = 32'hF00E0020;
  logic core_clk_i = 0, arst_n_i = 0, psel_i = 0, penable_i = 0;
  logic pwrite_i = 0, fifo_read_i = 0, fifo_write_i = 0, err;
  logic [31:0] paddr_i = 0, pwdata_i = 0, rd;
  wire [31:0] prdata_o;
  wire [5:0] max_packet_bytes_o;
  wire pready_o, pslverr_o, dir_in_o, out_iso_o, in_iso_o, fifo_write_ok_o;
  wire out_packet_ready_o, in_packet_ready_o, in_pkt_sent_i;
  wire out_pkt_loaded_i, out_pkt_error_i, out_load_fail_i;
  int n_errors = 0, num_checks = 0;
  uec_ep2_csr uec_ep2_csr_inst (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .out_pkt_loaded_i(out_pkt_loaded_i),
    .out_pkt_error_i(out_pkt_error_i), .out_load_fail_i(out_load_fail_i),
    .fifo_read_i(fifo_read_i), .fifo_write_i(fifo_write_i),
    .in_pkt_sent_i(in_pkt_sent_i), .max_packet_bytes_o(max_packet_bytes_o),
    .dir_in_o(dir_in_o), .out_iso_o(out_iso_o), .in_iso_o(in_iso_o),
    .fifo_write_ok_o(fifo_write_ok_o),
    .out_packet_ready_o(out_packet_ready_o),
    .in_packet_ready_o(in_packet_ready_o));
  uec_usb_core_model uec_usb_core_model_inst (.clk_i(core_clk_i),
    .in_ready_i(in_packet_ready_o), .pkt_loaded_o(out_pkt_loaded_i),
    .pkt_error_o(out_pkt_error_i), .load_fail_o(out_load_fail_i),
    .pkt_sent_o(in_pkt_sent_i));
  initial forever #50 core_clk_i = ~core_clk_i;
  // one apb transfer, read data taken at the pready edge
  task automatic apb(input logic w, input logic [31:0] a, d);
    @(posedge core_clk_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
    @(posedge core_clk_i);
    penable_i <= 1;
    do begin
      @(posedge core_clk_i);
    end while (pready_o !== 1'b1);
    // taken at the edge that samples pready, before release
    {rd, err} = {prdata_o, pslverr_o};
    {psel_i, penable_i} <= 2'b00;
    @(negedge core_clk_i);
  endtask
  task automatic chk(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [31:0] exp);
    apb(0, CSR, 0);
    chk(rd, exp);
  endtask
  // n byte strobes into (w=1) or out of the fifo
  task automatic bytes(input logic w, input int n);
    repeat (n) begin
      @(posedge core_clk_i);
      {fifo_write_i, fifo_read_i} <= {w, !w};
    end
    @(posedge core_clk_i);
    {fifo_write_i, fifo_read_i} <= 2'b00;
    @(negedge core_clk_i);
  endtask
  task automatic complete_run();
    if (n_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge core_clk_i);
    arst_n_i <= 1;
    rdc(32'h401);
    apb(0, CSR + 4, 0);
    chk(err, 1);
    for (int c = 0; c < 5; c++) begin
      apb(1, CSR, 32'h80 | c);
      chk(max_packet_bytes_o, c * 8);
    end
    apb(1, CSR, 32'h6078);
    rdc(32'h404);
    apb(1, CSR, 32'h8381);
    rdc(32'h301);
    chk(out_iso_o, 1);
    uec_usb_core_model_inst.load(0);
    uec_usb_core_model_inst.load(1);
    rdc(32'h30301);
    bytes(0, 8);
    rdc(32'h90301);
    apb(1, CSR, 32'h10000);
    rdc(32'h301);
    uec_usb_core_model_inst.fail();
    rdc(32'h40301);
    apb(1, CSR, 32'h40000);
    apb(1, CSR, 32'h9C01);
    rdc(32'h1C01);
    chk({in_iso_o, out_iso_o}, 2'b10);
    bytes(1, 8);
    rdc(32'h1001C01);
    chk(fifo_write_ok_o, 0);
    for (int i = 0; i < 50 && in_packet_ready_o !== 1'b0; i++)
      @(negedge core_clk_i);
    chk(in_packet_ready_o, 0);
    bytes(1, 3);
    chk(in_packet_ready_o, 0);
    apb(1, CSR, 32'h1000000);
    chk(in_packet_ready_o, 1);
    complete_run();
  end
endmodule // testbench
bind uec_ep2_csr uec_ep2_checker uec_ep2_checker_inst (.*);

// [tb/uec_ep2_checker.sv]
`timescale 1ns/1ps
// port-level checks of the endpoint 2 register block
module uec_ep2_checker (
  // clock, reset and apb
  input wire core_clk_i, arst_n_i, psel_i, penable_i, pwrite_i,
  input wire [31:0] paddr_i, pwdata_i, prdata_o,
  input wire pready_o, pslverr_o,
  // endpoint side
  input wire out_pkt_loaded_i, fifo_read_i, fifo_write_i, in_pkt_sent_i,
  input wire [5:0] max_packet_bytes_o,
  input wire dir_in_o, out_iso_o, in_iso_o, fifo_write_ok_o,
  input wire out_packet_ready_o, in_packet_ready_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  // decode of the access phase
  wire acc = psel_i && penable_i;
  wire hit = paddr_i == 32'hF00E0020;
  wire wr = acc && pwrite_i && hit;
  sequence size_wr;
    wr && pwdata_i[7] && pwdata_i[2:0] <= 3'h4;
  endsequence
  zero_wait_a: assert property (acc |-> pready_o)
    else $error("pready low in access");
  unmapped_err_a: assert property (acc && !hit |-> pslverr_o)
    else $error("no error on unmapped access");
  rsvd_read_a: assert property
    (acc |-> !(prdata_o & 32'hFEF0E0F8))
    else $error("reserved bits read nonzero");
  size_map_a: assert property
    (size_wr |=> max_packet_bytes_o == {$past(pwdata_i[2:0]), 3'h0})
    else $error("size decode wrong");
  size_keep_a: assert property
    (wr && !pwdata_i[7] |=> $stable(max_packet_bytes_o))
    else $error("size changed without enable");
  dir_set_a: assert property
    (wr && pwdata_i[15] |=> dir_in_o == $past(pwdata_i[10]))
    else $error("direction not written");
  dir_keep_a: assert property
    (!(wr && pwdata_i[15]) |=> $stable(dir_in_o))
    else $error("direction changed without enable");
  iso_gate_a: assert property
    (!(out_iso_o && dir_in_o) && !(in_iso_o && !dir_in_o))
    else $error("iso select active in wrong direction");
  write_ok_a: assert property
    (fifo_write_ok_o == (dir_in_o && !in_packet_ready_o))
    else $error("fifo write enable wrong");
  out_ready_a: assert property
    (out_pkt_loaded_i && !dir_in_o && !fifo_read_i && !wr
     |=> out_packet_ready_o)
    else $error("OUT ready not set on load");
  in_sent_a: assert property
    (in_pkt_sent_i && !wr && !fifo_write_i |=> !in_packet_ready_o)
    else $error("IN ready not cleared on send");
endmodule // uec_ep2_checker

// [tb/uec_usb_core_model.sv]
`timescale 1ns/1ps
// usb core stand-in: loads OUT packets, sends IN packets after a delay
module uec_usb_core_model #(
  parameter SEND_DLY = 20
) (
  input wire clk_i,
  input wire in_ready_i,
  output reg pkt_loaded_o,
  output reg pkt_error_o,
  output reg load_fail_o,
  output reg pkt_sent_o
);
  integer wait_q;
  initial begin
    {pkt_loaded_o, pkt_error_o, load_fail_o, pkt_sent_o} = 4'h0;
    wait_q = 0;
  end
  // one OUT packet lands in the fifo, err marks a crc or stuff fault
  task automatic load(input logic err);
    @(posedge clk_i);
    pkt_loaded_o <= 1'b1;
    pkt_error_o <= err;
    @(posedge clk_i);
    pkt_loaded_o <= 1'b0;
    pkt_error_o <= 1'b0;
  endtask
  // an iso packet that found no room
  task automatic fail();
    @(posedge clk_i);
    load_fail_o <= 1'b1;
    @(posedge clk_i);
    load_fail_o <= 1'b0;
  endtask
  // send the IN packet some cycles after it was marked ready
  always @(posedge clk_i) begin
    pkt_sent_o <= 1'b0;
    if (in_ready_i && !pkt_sent_o) begin
      wait_q <= wait_q + 1;
      if (wait_q == SEND_DLY) begin
        pkt_sent_o <= 1'b1;
        wait_q <= 0;
      end
    end
  end
endmodule // uec_usb_core_model
